// [rtl/pse_highpower_watchdog_regs.v]
// high-power configuration, turn-on gate, bus watchdog and id registers
`timescale 1ns/1ps
`include "pse_defines.vh"
// Notes on behaviour
// - high-power bit raises limit and short thresholds
// - fault timer runs on limit or enabled cut
// - inrush profile independent of high-power bit
// - set loads police 0x0, clear loads 0xF
// - limit time nominal unless high-power set
// - pushbutton class 4 sets bit, police 08h
// - gate set, semiauto with detect enabled: power on if detect valid and timing met, or on the retry if detect valid
// - timing missed: redetect, classify, single retry
// - gate clear: power on immediately
// - firmware revision read-only at 41h
// - any scl edge restarts watchdog
// - watchdog expires after 2 seconds idle
// - expiry sets flag, unmasked turns ports off
// - disable code resets 1011b, that masks
// - flag kept while masked, host writes zero
// - watchdog turn-off clears port events and enables
// - change events only on real state change
// - flag set freezes temperature and voltage updates
// - identity: device code high, silicon rev low
// - watchdog byte 42h, config byte 40h
module pse_highpower_watchdog_regs
#(
   parameter PORTS         = 4,
   parameter WD_CYCLES     = `PSE_WD_CYCLES,
   parameter CLASS4_CYCLES = `PSE_CLASS4_CYCLES,
   parameter [7:0] FW_REV  = 8'h01,   // arbitrary value
   parameter [2:0] DEV_CODE = 3'h2,   // arbitrary value
   parameter [4:0] SIL_REV = 5'h01    // arbitrary value
)
(
   input  wire             mclk,
   input  wire             reset_n,
   input  wire             sclIn,
   input  wire             regWrite,
   input  wire             regRead,
   input  wire [7:0]       regCmd,
   input  wire [7:0]       regWdata,
   output reg  [7:0]       regRdata,
   input  wire             semiautoMode,
   input  wire [PORTS-1:0] detectEnableBit,
   input  wire [PORTS-1:0] cutEnable,
   input  wire [PORTS-1:0] overLimit,
   input  wire [PORTS-1:0] overCut,
   input  wire [PORTS-1:0] powerOnCmd,
   input  wire [PORTS-1:0] detectDone,
   input  wire [PORTS-1:0] detectValid,
   input  wire [PORTS-1:0] timingMet,
   input  wire [PORTS-1:0] inrushDone,
   input  wire [PORTS-1:0] pushbuttonOn,
   input  wire [PORTS-1:0] class4Seen,
   input  wire [PORTS-1:0] portPowered,
   input  wire [PORTS-1:0] portGood,
   output reg  [PORTS-1:0] highPowerPortEn,
   output wire             turnOnTimingGate,
   output wire [PORTS-1:0] limitScaleHigh,
   output wire [PORTS-1:0] faultTimerRun,
   output wire [PORTS-1:0] limitTimeProgrammed,
   output wire [PORTS-1:0] inrushProfileNormal,
   output reg  [PORTS-1:0] policeLoad,
   output reg  [4*PORTS-1:0] policeValue,
   output reg  [PORTS-1:0] portTurnOn,
   output reg  [PORTS-1:0] redetectReq,
   output reg  [PORTS-1:0] portForceOff,
   output reg  [PORTS-1:0] eventsClear,
   output reg  [PORTS-1:0] powerEnableChange,
   output reg  [PORTS-1:0] powerGoodChange,
   output reg  [PORTS-1:0] powerEnableState,
   output reg  [PORTS-1:0] powerGoodState,
   output wire             monitorFreeze,
   output reg              watchdogExpiredFlag,
   output reg  [3:0]       watchdogDisableCode
);
   // ***********************************
   // watchdog timer
   // ***********************************
   wire expirePulse;
   pse_wd_timer #(.TIMEOUT(WD_CYCLES)) uTimer
   (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .sclIn       (sclIn),
      .expirePulse (expirePulse)
   );
   reg                 turnOnGate;
   reg  [PORTS-1:0]    armed;
   reg  [PORTS-1:0]    retry;
   reg  [PORTS-1:0]    class4Pend;
   reg  [23:0]         class4Cnt [0:PORTS-1];
   reg  [PORTS-1:0]    offPend;
   localparam [7:0]    POL_CLASS4 = `PSE_POL_CLASS4;
   wire wdMasked  = (watchdogDisableCode == `PSE_WD_MASK_CODE);
   wire wrHp      = regWrite && (regCmd == `PSE_CMD_HP_CFG);
   wire wrWd      = regWrite && (regCmd == `PSE_CMD_WD_CTRL);
   wire wdKill    = expirePulse && !wdMasked;
   wire [PORTS-1:0] wrHpBits = regWdata[`PSE_HP_EN_MSB:`PSE_HP_EN_LSB];
   assign turnOnTimingGate    = turnOnGate;
   assign limitScaleHigh      = highPowerPortEn;
   assign faultTimerRun       = overLimit | (overCut & cutEnable);
   assign limitTimeProgrammed = highPowerPortEn;
   assign inrushProfileNormal = {PORTS{1'b1}};
   assign monitorFreeze       = watchdogExpiredFlag;
   // ***********************************
   // register read
   // ***********************************
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         case (regCmd)
            `PSE_CMD_HP_CFG:  regRdata <= {highPowerPortEn, 3'h0, turnOnGate};
            `PSE_CMD_FW_REV:  regRdata <= FW_REV;
            `PSE_CMD_WD_CTRL: regRdata <= {3'h0, watchdogDisableCode, watchdogExpiredFlag};
            `PSE_CMD_DEV_ID:  regRdata <= {DEV_CODE, SIL_REV};
            default:          regRdata <= 8'h00;
         endcase
      end
   end
   // ***********************************
   // watchdog control
   // ***********************************
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         watchdogDisableCode <= `PSE_WD_MASK_CODE;
         watchdogExpiredFlag <= 1'b0;
      end
      else
      begin
         if (wrWd)
            watchdogDisableCode <= regWdata[`PSE_WD_CODE_MSB:`PSE_WD_CODE_LSB];
         if (expirePulse)
            watchdogExpiredFlag <= 1'b1;
         else if (wrWd && !regWdata[`PSE_WD_FLAG_BIT])
            watchdogExpiredFlag <= 1'b0;
      end
   end
   // ***********************************
   // per-port high-power, gate and turn-off
   // ***********************************
   genvar p;
   generate
      for (p = 0; p < PORTS; p = p + 1)
      begin : gPort
         wire c4Done = class4Pend[p] && (class4Cnt[p] == CLASS4_CYCLES[23:0] - 24'h1);
         always @(posedge mclk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               highPowerPortEn[p]     <= 1'b0;
               policeLoad[p]          <= 1'b0;
               policeValue[4*p+3:4*p] <= 4'h0;
               class4Pend[p]          <= 1'b0;
               class4Cnt[p]           <= 24'h0;
               armed[p]               <= 1'b0;
               retry[p]               <= 1'b0;
               portTurnOn[p]          <= 1'b0;
               redetectReq[p]         <= 1'b0;
               portForceOff[p]        <= 1'b0;
               eventsClear[p]         <= 1'b0;
               offPend[p]             <= 1'b0;
               powerEnableChange[p]   <= 1'b0;
               powerGoodChange[p]     <= 1'b0;
               powerEnableState[p]    <= 1'b0;
               powerGoodState[p]      <= 1'b0;
            end
            else
            begin
               policeLoad[p]   <= 1'b0;
               portTurnOn[p]   <= 1'b0;
               redetectReq[p]  <= 1'b0;
               portForceOff[p] <= 1'b0;
               eventsClear[p]  <= 1'b0;
               powerEnableChange[p] <= 1'b0;
               powerGoodChange[p]   <= 1'b0;
               // class-4 pushbutton: set bit within window after inrush
               if (pushbuttonOn[p] && class4Seen[p] && inrushDone[p])
               begin
                  class4Pend[p] <= 1'b1;
                  class4Cnt[p]  <= 24'h0;
               end
               else if (class4Pend[p])
                  class4Cnt[p] <= class4Cnt[p] + 24'h1;
               if (c4Done)
               begin
                  class4Pend[p]          <= 1'b0;
                  highPowerPortEn[p]     <= 1'b1;
                  policeLoad[p]          <= 1'b1;
                  policeValue[4*p+3:4*p] <= POL_CLASS4[3:0];
               end
               else if (wrHp && (wrHpBits[p] != highPowerPortEn[p]))
               begin
                  highPowerPortEn[p]     <= wrHpBits[p];
                  policeLoad[p]          <= 1'b1;
                  policeValue[4*p+3:4*p] <= wrHpBits[p] ? `PSE_POL_HP_SET
                                                        : `PSE_POL_HP_CLR;
               end
               // power-on command handling
               if (wdKill)
               begin
                  armed[p] <= 1'b0;
                  retry[p] <= 1'b0;
               end
               else if (powerOnCmd[p])
               begin
                  if (!turnOnGate || !semiautoMode || !detectEnableBit[p])
                     portTurnOn[p] <= 1'b1;
                  else
                  begin
                     armed[p] <= 1'b1;
                     retry[p] <= 1'b0;
                  end
               end
               else if (armed[p] && detectDone[p])
               begin
                  if (retry[p])
                  begin
                     armed[p]      <= 1'b0;
                     portTurnOn[p] <= detectValid[p];
                  end
                  else if (detectValid[p] && timingMet[p])
                  begin
                     armed[p]      <= 1'b0;
                     portTurnOn[p] <= 1'b1;
                  end
                  else
                  begin
                     retry[p]       <= 1'b1;
                     redetectReq[p] <= 1'b1;
                  end
               end
               // watchdog turn-off and status tracking
               if (wdKill)
               begin
                  portForceOff[p] <= 1'b1;
                  eventsClear[p]  <= 1'b1;
                  offPend[p]      <= 1'b1;
               end
               else if (offPend[p])
               begin
                  offPend[p]             <= 1'b0;
                  powerEnableChange[p]   <= powerEnableState[p];
                  powerGoodChange[p]     <= powerGoodState[p];
                  powerEnableState[p]    <= 1'b0;
                  powerGoodState[p]      <= 1'b0;
               end
               else
               begin
                  powerEnableState[p] <= portPowered[p];
                  powerGoodState[p]   <= portGood[p];
               end
            end
         end
      end
   endgenerate
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         turnOnGate <= 1'b0;
      else if (wrHp)
         turnOnGate <= regWdata[`PSE_TURN_ON_TIMING_GATE_BIT];
   end
endmodule // pse_highpower_watchdog_regs

// [pkg/pse_defines.vh]
// constants for the high-power and watchdog register bank
`ifndef PSE_DEFINES_VH
`define PSE_DEFINES_VH
`define PSE_CMD_HP_CFG       8'h40
`define PSE_CMD_FW_REV       8'h41
`define PSE_CMD_WD_CTRL      8'h42
`define PSE_CMD_DEV_ID       8'h43
`define PSE_HP_EN_MSB        7
`define PSE_HP_EN_LSB        4
`define PSE_TURN_ON_TIMING_GATE_BIT         0
`define PSE_HP_CFG_RESET     8'h00
`define PSE_WD_CODE_MSB      4
`define PSE_WD_CODE_LSB      1
`define PSE_WD_FLAG_BIT      0
`define PSE_WD_MASK_CODE     4'hb
`define PSE_POL_HP_SET       4'h0
`define PSE_POL_HP_CLR       4'hf
`define PSE_POL_CLASS4       8'h08
`define PSE_CLK_HZ           10000000
`define PSE_WD_TIMEOUT_MS    2000
`define PSE_WD_CYCLES        (`PSE_CLK_HZ / 1000 * `PSE_WD_TIMEOUT_MS)
`define PSE_LIMIT_FAULT_TIME_NOM_MS      60
`define PSE_CLASS4_SET_MS    5
`define PSE_CLASS4_CYCLES    (`PSE_CLK_HZ / 1000 * `PSE_CLASS4_SET_MS)
`endif

// [rtl/pse_wd_timer.v]
// bus watchdog: scl synchroniser, edge detect, timeout counter
`timescale 1ns/1ps
module pse_wd_timer
#(
   parameter TIMEOUT = 20000000
)
(
   input  wire mclk,
   input  wire reset_n,
   input  wire sclIn,
   output reg  expirePulse
);
   reg        sclMeta;
   reg        sclSync;
   reg        sclLast;
   reg [31:0] count;
   wire       sclEdge = sclSync ^ sclLast;
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclMeta     <= 1'b1;                         // scl idles high
         sclSync     <= 1'b1;
         sclLast     <= 1'b1;
         count       <= 32'h0;
         expirePulse <= 1'b0;
      end
      else
      begin
         sclMeta     <= sclIn;
         sclSync     <= sclMeta;
         sclLast     <= sclSync;
         expirePulse <= 1'b0;
         if (sclEdge)
            count <= 32'h0;
         else if (count == TIMEOUT - 1)
         begin
            count       <= 32'h0;
            expirePulse <= 1'b1;
         end
         else
            count <= count + 32'h1;
      end
   end
endmodule // pse_wd_timer

// [bench/pse_hpwd_props.sv]
// concurrent checks for the high-power and watchdog register bank
`timescale 1ns/1ps
module pse_hpwd_props
#(
   parameter PORTS     = 4,
   parameter WD_CYCLES = 50
)
(
   input wire               mclk,
   input wire               reset_n,
   input wire               sclIn,
   input wire               regWrite,
   input wire [7:0]         regCmd,
   input wire [7:0]         regWdata,
   input wire [PORTS-1:0]   powerOnCmd,
   input wire [PORTS-1:0]   highPowerPortEn,
   input wire               turnOnTimingGate,
   input wire [PORTS-1:0]   limitScaleHigh,
   input wire [PORTS-1:0]   policeLoad,
   input wire [4*PORTS-1:0] policeValue,
   input wire [PORTS-1:0]   portTurnOn,
   input wire [PORTS-1:0]   portForceOff,
   input wire [PORTS-1:0]   powerEnableChange,
   input wire [PORTS-1:0]   powerEnableState,
   input wire               monitorFreeze,
   input wire               watchdogExpiredFlag,
   input wire [3:0]         watchdogDisableCode
);
   // ****************************************
   // scl idle counter and assertions
   // ****************************************
   reg sclLast;
   int idle;
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclLast <= 1'b1;
         idle <= 0;
      end
      else
      begin
         sclLast <= sclIn;
         idle <= (sclIn != sclLast) ? 0 : idle + 1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_limit_scale: assert property (limitScaleHigh == highPowerPortEn)
      else $error("limit scale not tied to high-power bit");
   a_police_set: assert property (regWrite && regCmd == 8'h40 && regWdata[4]
      && !highPowerPortEn[0] |=> policeLoad[0] && policeValue[3:0] == 4'h0)
      else $error("police not loaded with 0 on set");
   a_police_clr: assert property (regWrite && regCmd == 8'h40 && !regWdata[4]
      && highPowerPortEn[0] |=> policeLoad[0] && policeValue[3:0] == 4'hf)
      else $error("police not loaded with f on clear");
   a_cfg_write: assert property (regWrite && regCmd == 8'h40
      |=> {highPowerPortEn, 3'h0, turnOnTimingGate} == ($past(regWdata) & 8'hf1))
      else $error("config write not applied");
   a_gate_bypass: assert property (powerOnCmd[1] && !turnOnTimingGate
      |-> ##[1:2] portTurnOn[1])
      else $error("power-on not immediate with gate clear");
   a_wd_idle: assert property ($rose(watchdogExpiredFlag) |-> idle >= WD_CYCLES - 2)
      else $error("watchdog expired too early");
   a_wd_off: assert property ($rose(watchdogExpiredFlag)
      |-> portForceOff == {PORTS{watchdogDisableCode != 4'hb}})
      else $error("port off does not follow mask");
   a_change_evt: assert property (portForceOff[0]
      |=> powerEnableChange == $past(powerEnableState))
      else $error("change events wrong after turn-off");
   a_freeze_flag: assert property (monitorFreeze == watchdogExpiredFlag)
      else $error("monitor freeze not following flag");
   cover property ($rose(watchdogExpiredFlag) && watchdogDisableCode != 4'hb);
   cover property (policeLoad[0] && policeValue[3:0] == 4'h8);
   cover property (portTurnOn[2]);
endmodule // pse_hpwd_props
bind pse_highpower_watchdog_regs pse_hpwd_props
   #(.PORTS(PORTS), .WD_CYCLES(WD_CYCLES)) pse_hpwd_props_inst (.*);

// [bench/pse_host_model.sv]
// host controller model: register strobes and scl activity
`timescale 1ns/1ps
module pse_host_model
(
   input  wire       mclk,
   input  wire [7:0] regRdata,
   output reg        sclIn = 1'b1,
   output reg        regWrite = 1'b0,
   output reg        regRead = 1'b0,
   output reg  [7:0] regCmd = 8'h00,
   output reg  [7:0] regWdata = 8'h00
);
   // ****************************************
   // bus tasks
   // ****************************************
   task wr(input [7:0] cmd, input [7:0] data);
      @(posedge mclk);
      regWrite <= 1'b1;
      regCmd <= cmd;
      regWdata <= data;
      @(posedge mclk);
      regWrite <= 1'b0;
      regWdata <= ~data;
      #1;
   endtask
   task rd(input [7:0] cmd, output [7:0] data);
      @(posedge mclk);
      regRead <= 1'b1;
      regCmd <= cmd;
      @(posedge mclk);
      regRead <= 1'b0;
      regCmd <= ~cmd;
      @(posedge mclk);
      #1 data = regRdata;
   endtask
   // scl edges keep the device watchdog alive
   task scl_run(input integer n);
      repeat (n)
      begin
         repeat (2) @(posedge mclk);
         sclIn <= ~sclIn;
      end
   endtask
endmodule // pse_host_model

// [bench/test_pse_highpower_watchdog_regs.sv]
// self-checking bench for the high-power and watchdog register bank
`timescale 1ns/1ps
module test_pse_highpower_watchdog_regs;
   // ****************************************
   // signals, instances and helpers
   // ****************************************
   reg mclk = 0, reset_n = 0, semiautoMode = 0;
   reg [3:0] detectEnableBit = 0, cutEnable = 0, overLimit = 0, overCut = 0, powerOnCmd = 0;
   reg [3:0] detectDone = 0, detectValid = 0, timingMet = 0, inrushDone = 0, portGood = 0;
   reg [3:0] pushbuttonOn = 0, class4Seen = 0, portPowered = 0;
   wire sclIn, regWrite, regRead, turnOnTimingGate, monitorFreeze, watchdogExpiredFlag;
   wire [7:0] regCmd, regWdata, regRdata;
   wire [3:0] highPowerPortEn, limitScaleHigh, faultTimerRun, limitTimeProgrammed, policeLoad;
   wire [3:0] inrushProfileNormal, portTurnOn, redetectReq, portForceOff, eventsClear;
   wire [3:0] powerEnableChange, powerGoodChange, powerEnableState, powerGoodState;
   wire [3:0] watchdogDisableCode;
   wire [15:0] policeValue;
   integer n_fail = 0, cmp_count = 0;
   reg [7:0] rv;
   reg [3:0] seenOn, seenRe, seenPec, seenOff, seenPgc, polVal;
   // identity parameter values are arbitrary
   pse_highpower_watchdog_regs #(.WD_CYCLES(50), .CLASS4_CYCLES(10),
      .FW_REV(8'h5a), .DEV_CODE(3'h5), .SIL_REV(5'h0c)) pse_highpower_watchdog_regs_inst (.*);
   pse_host_model pse_host_model_inst (.*);
   always #50 mclk = ~mclk;
   task close_out;
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rdchk(input [7:0] cmd, input [7:0] exp);
      pse_host_model_inst.rd(cmd, rv);
      chk(rv, exp);
   endtask
   task kick(input [3:0] on, input [3:0] det, input [3:0] inr, input integer n);
      @(posedge mclk);
      powerOnCmd <= on;
      detectDone <= det;
      inrushDone <= inr;
      @(posedge mclk);
      powerOnCmd <= 4'h0;
      detectDone <= 4'h0;
      inrushDone <= 4'h0;
      {seenOn, seenRe, seenPec, seenOff, seenPgc, polVal} = {20'h0, 4'hf};
      repeat (n)
      begin
         #1;
         seenOn = seenOn | portTurnOn;
         seenRe = seenRe | redetectReq;
         seenPec = seenPec | powerEnableChange;
         seenPgc = seenPgc | powerGoodChange;
         seenOff = seenOff | (portForceOff & eventsClear);
         // port logic drops power once a port is forced off
         portPowered <= portPowered & ~portForceOff;
         portGood <= portGood & ~portForceOff;
         if (policeLoad[0])
            polVal = policeValue[3:0];
         @(posedge mclk);
      end
      #1;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      rdchk(8'h40, 8'h00);
      rdchk(8'h42, 8'h16);
      rdchk(8'h41, 8'h5a);
      rdchk(8'h43, 8'hac);
      rdchk(8'h44, 8'h00);
      overLimit <= 4'h1;
      overCut <= 4'ha;
      cutEnable <= 4'h6;
      pse_host_model_inst.wr(8'h40, 8'hff);
      rdchk(8'h40, 8'hf1);
      chk({4'h0, limitScaleHigh}, 8'h0f);
      chk({4'h0, limitTimeProgrammed}, 8'h0f);
      chk({4'h0, faultTimerRun}, 8'h03);
      chk({4'h0, inrushProfileNormal}, 8'h0f);
      pse_host_model_inst.wr(8'h41, 8'h00);
      rdchk(8'h41, 8'h5a);
      pse_host_model_inst.wr(8'h40, 8'h00);
   endtask
   task t_gate;
      semiautoMode <= 1'b1;
      detectEnableBit <= 4'hf;
      kick(4'h2, 4'h0, 4'h0, 4);
      chk({4'h0, seenOn}, 8'h02);
      pse_host_model_inst.wr(8'h40, 8'h01);
      detectValid <= 4'hc;
      timingMet <= 4'h4;
      kick(4'hc, 4'h0, 4'h0, 4);
      chk({4'h0, seenOn}, 8'h00);
      kick(4'h0, 4'h4, 4'h0, 4);
      chk({4'h0, seenOn}, 8'h04);
      kick(4'h0, 4'h8, 4'h0, 4);
      chk({seenRe, seenOn}, 8'h80);
      kick(4'h0, 4'h8, 4'h0, 4);
      chk({4'h0, seenOn}, 8'h08);
      kick(4'h0, 4'h8, 4'h0, 4);
      chk({4'h0, seenOn}, 8'h00);
   endtask
   task t_class4;
      pushbuttonOn <= 4'h1;
      class4Seen <= 4'h1;
      kick(4'h0, 4'h0, 4'h1, 16);
      chk({polVal, highPowerPortEn}, 8'h81);
   endtask
   task t_wd;
      portPowered <= 4'h5;
      portGood <= 4'h4;
      rdchk(8'h42, 8'h17);
      pse_host_model_inst.scl_run(4);
      pse_host_model_inst.wr(8'h42, 8'h16);
      rdchk(8'h42, 8'h16);
      pse_host_model_inst.wr(8'h42, 8'h00);
      pse_host_model_inst.scl_run(40);
      rdchk(8'h42, 8'h00);
      chk({powerGoodState, powerEnableState}, 8'h45);
      kick(4'h0, 4'h0, 4'h0, 70);
      chk({seenOff, seenPec}, 8'hf5);
      chk({4'h0, seenPgc}, 8'h04);
      chk({4'h0, powerGoodState}, 8'h00);
      chk({monitorFreeze, watchdogExpiredFlag, powerEnableState}, 8'h30);
      pse_host_model_inst.wr(8'h42, 8'h00);
      chk({7'h0, monitorFreeze}, 8'h00);
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs;
      t_gate;
      t_class4;
      t_wd;
      close_out;
   end
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      close_out;
   end
endmodule // test_pse_highpower_watchdog_regs
